// ===== spi_master_serial_port.sv
/*
  Serial peripheral master: one character of 2 to 16 bits per start pulse,
  two chip selects, prescaled serial clock, selectable polarity and phase.
  Assumes start_i and the configuration inputs come from logic on ref_clk_i,
  and serial_data_in_i comes from an external slave with no timing relation.
*/
// Behaviour
// (RQ1) The block is master only and always drives the serial clock itself.
// (RQ2) Two active-low chip selects address either of two slaves.
// (RQ3) The link runs three-wire without a select, or four-wire with one.
// (RQ4) Characters are 2 to 16 bits through a 16-bit shift register into a receive buffer.
// (RQ5) The block has its own interrupt output for its events.
// (RQ6) Separate receive and transmit DMA events are raised.
// (RQ7) The serial clock is the module clock divided by an 8-bit prescaler.
// (RQ8) Clock phase (no delay or half-cycle delay) and polarity are selectable.
// (RQ9) Phase 0, polarity 0: sample on falling edge, change output on rising edge.
// (RQ10) Phase 0, polarity 1: change output on falling edge, sample on rising edge.
// (RQ11) At least two module cycles, plus a programmable delay, pass from select low to the first clock edge.
// (RQ12) Select is held at least one module cycle plus half a serial clock, plus a programmable delay, after the last edge.
// (RQ13) The pins offer no general-purpose input/output use.
// (RQ14) Between transfers the serial clock rests at the polarity level.
// (RQ15) After the last bit the received character goes to the buffer and completion is signalled.
`timescale 1ns/100ps

module spi_master_serial_port (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic [15:0] tx_data_i,
  input  wire logic [4:0]  char_len_i,
  input  wire logic [7:0]  prescale_i,
  input  wire logic        clk_pol_i,
  input  wire logic        clk_pha_i,
  input  wire logic        cs_sel_i,
  input  wire logic        four_wire_i,
  input  wire logic [7:0]  select_to_transfer_delay_i,
  input  wire logic [7:0]  transfer_to_select_delay_i,
  input  wire logic        serial_data_in_i,
  output logic             sclk_o,
  output logic             serial_data_out_o,
  output logic [1:0]       cs_n_o,
  output logic [15:0]      rx_data_o,
  output logic             busy_o,
  output logic             irq_o,
  output logic             rx_dma_o,
  output logic             tx_dma_o
);

  spi_master_serial_port_pkg::state_t state_r;

  logic        s1_r;
  logic        s2_r;
  logic        s3_r;
  logic        din_r;
  logic [4:0]  len_r;
  logic [7:0]  presc_r;
  logic [7:0]  t2c_r;
  logic        cpol_r;
  logic        cpha_r;
  logic        four_r;
  logic [8:0]  ld_r;
  logic [7:0]  hc_r;
  logic [9:0]  tc_r;
  logic [4:0]  edge_r;
  logic [15:0] sh_r;
  logic [15:0] rx_sh_r;
  logic [4:0]  samp_r;
  logic        sclk_r;
  logic        sdo_r;
  logic [1:0]  cs_n_r;
  logic [15:0] rx_data_r;
  logic        busy_r;
  logic        irq_r;
  logic        rx_dma_r;
  logic        tx_dma_r;

  // Out-of-range lengths and prescales are clamped rather than refused.
  wire [4:0]  len_eff   = (char_len_i < spi_master_serial_port_pkg::LEN_MIN) ?
                          spi_master_serial_port_pkg::LEN_MIN :
                          ((char_len_i > spi_master_serial_port_pkg::LEN_MAX) ?
                           spi_master_serial_port_pkg::LEN_MAX : char_len_i);
  wire [7:0]  presc_eff = (prescale_i < spi_master_serial_port_pkg::PRESC_MIN) ?
                          spi_master_serial_port_pkg::PRESC_MIN : prescale_i;
  wire [4:0]  pad       = 5'h10 - len_eff;
  wire [15:0] tx_al     = tx_data_i << pad;
  wire        accept    = start_i && (state_r == spi_master_serial_port_pkg::ST_IDLE);
  wire        tick      = (state_r == spi_master_serial_port_pkg::ST_SHIFT) && (hc_r == 8'h00);
  wire [5:0]  last_idx  = {len_r, 1'b0} - 6'h01;
  wire        last      = ({1'b0, edge_r} == last_idx);
  wire        lead_edge = !edge_r[0];
  // Phase 0 changes data on leading edges and samples on trailing ones.
  wire        drv       = tick && (cpha_r ? (!lead_edge && !last) : lead_edge); // see RQ8
  wire        smp       = tick && (cpha_r ? lead_edge : !lead_edge); // see RQ9 see RQ10
  wire [15:0] rx_next   = smp ? {rx_sh_r[14:0], din_r} : rx_sh_r;
  wire [1:0]  cs_pick   = cs_sel_i ? spi_master_serial_port_pkg::CS_N_SEL1 :
                          spi_master_serial_port_pkg::CS_N_SEL0;
  wire [9:0]  trail_ld  = 10'(spi_master_serial_port_pkg::TRAIL_MIN_CYC) +
                          {2'b00, presc_r} + {2'b00, t2c_r};
  wire [8:0]  lead_ld   = 9'(spi_master_serial_port_pkg::LEAD_MIN_CYC - 1) +
                          {1'b0, select_to_transfer_delay_i};

  // The input is asynchronous; a level counts only when two stages agree.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r  <= 1'b0;
      s2_r  <= 1'b0;
      s3_r  <= 1'b0;
      din_r <= 1'b0;
    end else begin
      s1_r <= serial_data_in_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        din_r <= s3_r;
      end
    end
  end

  // Configuration is frozen per frame so a change mid-frame cannot tear it.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      len_r   <= spi_master_serial_port_pkg::LEN_MIN;
      presc_r <= spi_master_serial_port_pkg::PRESC_MIN;
      t2c_r   <= 8'h00;
      cpol_r  <= 1'b0;
      cpha_r  <= 1'b0;
      four_r  <= 1'b0;
    end else if (accept) begin
      len_r   <= len_eff; // see RQ4
      presc_r <= presc_eff; // see RQ7
      t2c_r   <= transfer_to_select_delay_i;
      cpol_r  <= clk_pol_i;
      cpha_r  <= clk_pha_i;
      four_r  <= four_wire_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= spi_master_serial_port_pkg::ST_IDLE;
      busy_r  <= 1'b0;
      cs_n_r  <= spi_master_serial_port_pkg::CS_N_RST;
      ld_r    <= 9'h000;
      hc_r    <= 8'h00;
      tc_r    <= 10'h000;
      edge_r  <= 5'h00;
    end else begin
      unique case (state_r)
        spi_master_serial_port_pkg::ST_IDLE: begin
          if (accept) begin
            state_r <= spi_master_serial_port_pkg::ST_LEAD;
            busy_r  <= 1'b1;
            ld_r    <= lead_ld; // see RQ11
            cs_n_r  <= four_wire_i ? cs_pick : spi_master_serial_port_pkg::CS_N_RST; // see RQ2 see RQ3
          end
        end
        spi_master_serial_port_pkg::ST_LEAD: begin
          if (ld_r == 9'h000) begin
            state_r <= spi_master_serial_port_pkg::ST_SHIFT;
            hc_r    <= presc_r;
            edge_r  <= 5'h00;
          end else begin
            ld_r <= ld_r - 9'h001;
          end
        end
        spi_master_serial_port_pkg::ST_SHIFT: begin
          if (tick) begin
            hc_r   <= presc_r; // see RQ7
            edge_r <= edge_r + 5'h01;
            if (last) begin
              state_r <= spi_master_serial_port_pkg::ST_TRAIL;
              tc_r    <= trail_ld; // see RQ12
            end
          end else begin
            hc_r <= hc_r - 8'h01;
          end
        end
        spi_master_serial_port_pkg::ST_TRAIL: begin
          if (tc_r == 10'h000) begin
            state_r <= spi_master_serial_port_pkg::ST_IDLE;
            busy_r  <= 1'b0;
            cs_n_r  <= spi_master_serial_port_pkg::CS_N_RST;
          end else begin
            tc_r <= tc_r - 10'h001;
          end
        end
      endcase
    end
  end

  // The clock is always ours; it follows the polarity input while idle.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_r <= 1'b0;
    end else if (state_r == spi_master_serial_port_pkg::ST_IDLE) begin
      sclk_r <= clk_pol_i; // see RQ1 see RQ14
    end else if (tick) begin
      sclk_r <= ~sclk_r;
    end
  end

  // Transmit is most significant bit first from the left-aligned character.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sh_r  <= 16'h0000;
      sdo_r <= spi_master_serial_port_pkg::SDO_RST;
    end else if (accept) begin
      sh_r <= clk_pha_i ? {tx_al[14:0], 1'b0} : tx_al; // see RQ4
      if (clk_pha_i) begin
        sdo_r <= tx_al[15]; // see RQ8
      end
    end else if (drv) begin
      sh_r  <= {sh_r[14:0], 1'b0};
      sdo_r <= sh_r[15]; // see RQ9 see RQ10
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_sh_r <= spi_master_serial_port_pkg::RX_RST;
      samp_r  <= 5'h00;
    end else if (accept) begin
      rx_sh_r <= spi_master_serial_port_pkg::RX_RST;
      samp_r  <= 5'h00;
    end else if (smp) begin
      rx_sh_r <= rx_next;
      samp_r  <= samp_r + 5'h01;
    end
  end

  // Completion fires on the last clock edge, before the select is released.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_data_r <= spi_master_serial_port_pkg::RX_RST;
      irq_r     <= 1'b0;
      rx_dma_r  <= 1'b0;
      tx_dma_r  <= 1'b0;
    end else begin
      if (tick && last) begin
        rx_data_r <= rx_next; // see RQ15
      end
      irq_r    <= tick && last; // see RQ5
      rx_dma_r <= tick && last; // see RQ6
      tx_dma_r <= accept; // see RQ6
    end
  end

  // The pins are serial only; no general-purpose path exists here (see RQ13).
  assign sclk_o            = sclk_r;
  assign serial_data_out_o = sdo_r;
  assign cs_n_o            = cs_n_r;
  assign rx_data_o         = rx_data_r;
  assign busy_o            = busy_r;
  assign irq_o             = irq_r;
  assign rx_dma_o          = rx_dma_r;
  assign tx_dma_o          = tx_dma_r;

  // Helper logic for the checks below: cycles since the last clock change.
  logic       sclk_q_r;
  logic [9:0] gap_r;
  logic       seen_r;
  wire        tgl    = (sclk_o != sclk_q_r);
  wire [9:0]  half_w = {2'b00, presc_r} + 10'h001;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_q_r <= 1'b0;
      gap_r    <= 10'h000;
      seen_r   <= 1'b0;
    end else begin
      sclk_q_r <= sclk_o;
      gap_r    <= tgl ? 10'h001 : ((gap_r == 10'h3ff) ? gap_r : gap_r + 10'h001);
      seen_r   <= busy_o && (seen_r || (tgl && (state_r != spi_master_serial_port_pkg::ST_LEAD)));
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_accept;
    start_i && !busy_o;
  endsequence

  sequence s_sclk_quiet;
    $stable(sclk_o) [*2];
  endsequence

  a_tx_dma_event: assert property (s_accept |=> tx_dma_o && busy_o) // see RQ6
    else $error("transmit event missing after accepted start");

  a_lead_quiet: assert property ($fell(&cs_n_o) |-> s_sclk_quiet) // see RQ11
    else $error("serial clock moved too soon after select");

  a_trail_hold: assert property ($rose(&cs_n_o) |->
      gap_r >= 10'(spi_master_serial_port_pkg::TRAIL_MIN_CYC) + half_w) // see RQ12
    else $error("select released too soon after last edge");

  a_half_period: assert property (busy_o && tgl && seen_r |-> gap_r == half_w) // see RQ7
    else $error("serial half period differs from prescale");

  a_rx_count: assert property (irq_o |-> samp_r == len_r && rx_dma_o) // see RQ15
    else $error("completion with wrong number of sampled bits");

  a_one_select: assert property (cs_n_o != 2'b00) // see RQ2
    else $error("both selects asserted");

  a_three_wire: assert property (busy_o && !four_r |-> cs_n_o == 2'b11) // see RQ3
    else $error("select driven in three-wire mode");

  a_idle_level: assert property (!busy_o && $past(busy_o) == 1'b0 |->
      sclk_o == $past(clk_pol_i) && cs_n_o == 2'b11) // see RQ14
    else $error("idle clock or select level wrong");

  a_sdo_pol0: assert property (busy_o && !cpha_r && !cpol_r && $fell(sclk_o) |->
      $stable(serial_data_out_o)) // see RQ9
    else $error("data moved on sampling edge, polarity 0");

  a_sdo_pol1: assert property (busy_o && !cpha_r && cpol_r && $rose(sclk_o) |->
      $stable(serial_data_out_o)) // see RQ10
    else $error("data moved on sampling edge, polarity 1");

endmodule

// ===== spi_master_serial_port_pkg.sv
/*
  Shared constants and the state type for the serial peripheral master.
  Assumes a 125 MHz module clock on ref_clk_i; the cycle counts below are
  derived from that clock period.
*/
package spi_master_serial_port_pkg;

  // Module clock period and the shortest legal serial clock period.
  localparam int CLK_PERIOD_PS      = 8000;
  localparam int SCLK_MIN_PERIOD_PS = 37037;
  // Least half period in module cycles, rounded up.
  localparam int SCLK_MIN_HALF_CYC  =
    (SCLK_MIN_PERIOD_PS + 2 * CLK_PERIOD_PS - 1) / (2 * CLK_PERIOD_PS);

  // Select-to-clock and clock-to-release minimums, in module clock periods.
  localparam int LEAD_MIN_P    = 2;
  localparam int TRAIL_MIN_P   = 1;
  localparam int LEAD_MIN_CYC  = LEAD_MIN_P * CLK_PERIOD_PS / CLK_PERIOD_PS;
  localparam int TRAIL_MIN_CYC = TRAIL_MIN_P * CLK_PERIOD_PS / CLK_PERIOD_PS;

  // Prescaler floor that keeps the serial clock within its least period.
  localparam logic [7:0] PRESC_MIN = 8'(SCLK_MIN_HALF_CYC - 1);

  // Character length limits and shift register width.
  localparam logic [4:0] LEN_MIN = 5'h02;
  localparam logic [4:0] LEN_MAX = 5'h10;
  localparam int         SHIFT_W = 16;

  // Chip-select patterns, active low: bit 0 is select 0, bit 1 is select 1.
  localparam logic [1:0] CS_N_RST = 2'h3;
  localparam logic [1:0] CS_N_SEL0 = 2'h2;
  localparam logic [1:0] CS_N_SEL1 = 2'h1;

  // Reset values of the data outputs.
  localparam logic              SDO_RST = 1'h0;
  localparam logic [SHIFT_W-1:0] RX_RST = 16'h0000;

  // Frame sequencer, Gray coded along idle, lead, shift, trail.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LEAD  = 2'b01,
    ST_SHIFT = 2'b11,
    ST_TRAIL = 2'b10
  } state_t;

endpackage

// ===== spi_slave_model.sv
/*
  Behavioural slave for the serial master: shifts a word out on the data-in line
  and captures what the master sends.
  Assumes the bench frames it with active_i and gives it the effective character length.
*/
`timescale 1ns/100ps

module spi_slave_model (
  input  wire logic        sclk_i,
  input  wire logic        active_i,
  input  wire logic        pha_i,
  input  wire logic        sdo_i,
  input  wire logic [15:0] word_i,
  input  wire logic [4:0]  len_i,
  input  wire logic [7:0]  lag_i,
  output logic             miso_o,
  output logic [15:0]      got_o
);
  int unsigned edges;
  int          idx;

  initial begin
    miso_o = 1'h0;
    got_o  = 16'h0000;
    edges  = 0;
  end

  // With a half-cycle delay the first bit must stand before the first edge.
  always @(posedge active_i) begin
    edges = 0;
    got_o = 16'h0000;
    miso_o <= #(lag_i) pha_i ? word_i[len_i-5'h01] : ~miso_o;
  end

  // A released line shows the inverse of its last value, so a late sample cannot match by luck.
  always @(negedge active_i) miso_o <= ~miso_o;

  always @(sclk_i) begin
    if (active_i) begin
      edges = edges + 1;
      if (edges[0] == pha_i) begin
        got_o = {got_o[14:0], sdo_i};
      end else begin
        idx = pha_i ? edges / 2 : (edges - 1) / 2;
        miso_o <= #(lag_i) (idx < len_i) ? word_i[len_i-5'h01-idx] : ~miso_o;
      end
    end
  end
endmodule

// ===== spi_master_serial_port_bench.sv
/*
  Self-checking bench for the serial master: frames in every clock mode with a slave model.
  Assumes a 125 MHz clock and that the design holds its own assertions.
*/
`timescale 1ns/100ps

module spi_master_serial_port_bench;
  logic        ref_clk_i;
  logic        rst_i;
  logic        start_i;
  logic [15:0] tx_data_i;
  logic [4:0]  char_len_i;
  logic [7:0]  prescale_i;
  logic        clk_pol_i;
  logic        clk_pha_i;
  logic        cs_sel_i;
  logic        four_wire_i;
  logic [7:0]  c2t_i;
  logic [7:0]  t2c_i;
  logic        miso;
  logic        sclk_o;
  logic        sdo_o;
  logic [1:0]  cs_n_o;
  logic [15:0] rx_data_o;
  logic        busy_o;
  logic        irq_o;
  logic        rx_dma_o;
  logic        tx_dma_o;
  logic [15:0] sl_word;
  logic [4:0]  sl_len;
  logic [7:0]  sl_lag;
  logic [15:0] sl_got;
  logic        sl_active;
  int          errors;
  int          tests_run;
  int          frames;

  spi_master_serial_port dut_u (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .start_i(start_i), .tx_data_i(tx_data_i),
    .char_len_i(char_len_i), .prescale_i(prescale_i), .clk_pol_i(clk_pol_i),
    .clk_pha_i(clk_pha_i), .cs_sel_i(cs_sel_i), .four_wire_i(four_wire_i),
    .select_to_transfer_delay_i(c2t_i), .transfer_to_select_delay_i(t2c_i),
    .serial_data_in_i(miso), .sclk_o(sclk_o), .serial_data_out_o(sdo_o), .cs_n_o(cs_n_o),
    .rx_data_o(rx_data_o), .busy_o(busy_o), .irq_o(irq_o), .rx_dma_o(rx_dma_o),
    .tx_dma_o(tx_dma_o)
  );

  // Without a select the slave is framed by busy, as a three-wire slave would be by software.
  assign sl_active = four_wire_i ? ~cs_n_o[cs_sel_i] : busy_o;

  spi_slave_model slave_u (
    .sclk_i(sclk_o), .active_i(sl_active), .pha_i(clk_pha_i), .sdo_i(sdo_o),
    .word_i(sl_word), .len_i(sl_len), .lag_i(sl_lag), .miso_o(miso), .got_o(sl_got)
  );

  initial begin
    ref_clk_i = 1'h0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Mode bits are four-wire, select, phase, polarity; poke retries start in mid-frame.
  task automatic run_frame(input logic [15:0] tx, input logic [15:0] wd, input logic [4:0] len,
                           input logic [7:0] pre, input logic [3:0] mode, input logic [7:0] c2t,
                           input logic [7:0] t2c, input logic [7:0] lag, input logic poke);
    int          n, h, c, first, last, tog, irqs, irq_at, done_at, txs;
    logic        prev;
    logic [1:0]  cs_exp;
    logic [15:0] mask;
    n = (len < 5'h02) ? 2 : (len > 5'h10) ? 16 : int'(len);
    h = (pre < 8'h02) ? 3 : int'(pre) + 1;
    mask = 16'hffff >> (16 - n);
    cs_exp = !mode[3] ? spi_master_serial_port_pkg::CS_N_RST :
             mode[2] ? spi_master_serial_port_pkg::CS_N_SEL1 : spi_master_serial_port_pkg::CS_N_SEL0;
    sl_word = wd;
    sl_len = 5'(n);
    sl_lag = lag;
    {c, first, last, tog, irqs, irq_at, done_at, txs} = '0;
    @(posedge ref_clk_i);
    {tx_data_i, char_len_i, prescale_i, c2t_i, t2c_i} <= {tx, len, pre, c2t, t2c};
    {four_wire_i, cs_sel_i, clk_pha_i, clk_pol_i} <= mode;
    // The idle clock settles to a new polarity before the select falls.
    @(posedge ref_clk_i);
    start_i <= 1'h1;
    prev = mode[0];
    while (done_at == 0 && c < 3000) begin
      @(posedge ref_clk_i);
      start_i <= poke && c == 4;
      #1;
      c++;
      if (c == 1) check({15'h0, busy_o}, 16'h0001);
      if (c == 1 && mode[1]) check({15'h0, sdo_o}, {15'h0, tx[n-1]});
      if (tx_dma_o) txs++;
      if (sclk_o !== prev) begin
        tog++;
        last = c;
        if (tog == 1) first = c;
      end
      prev = sclk_o;
      if (tog == 0) check({14'h0, cs_n_o}, {14'h0, cs_exp});
      if (irq_o | rx_dma_o) begin
        irqs++;
        irq_at = c;
        check({15'h0, rx_dma_o}, {15'h0, irq_o});
        check(rx_data_o, wd & mask);
      end
      if (!busy_o) done_at = c;
    end
    check({15'h0, busy_o}, 16'h0000);
    check(16'(txs), 16'h0001);
    check(16'(first), 16'(3 + int'(c2t) + h));
    check(16'(tog), 16'(2 * n));
    check(16'(last - first), 16'((2 * n - 1) * h));
    check(16'(irqs), 16'h0001);
    check(16'(irq_at), 16'(last));
    check(16'(done_at - last), 16'(1 + h + int'(t2c)));
    check({14'h0, cs_n_o}, {14'h0, spi_master_serial_port_pkg::CS_N_RST});
    check({15'h0, sclk_o}, {15'h0, mode[0]});
    check(sl_got & mask, tx & mask);
    frames++;
    $display("test %0d done", frames);
  endtask

  initial begin
    {rst_i, start_i, tx_data_i, char_len_i, prescale_i, clk_pol_i, clk_pha_i} = '0;
    {cs_sel_i, four_wire_i, c2t_i, t2c_i, sl_word, sl_len, sl_lag} = '0;
    {errors, tests_run, frames} = '0;
    rst_i = 1'h1;
    repeat (10) @(posedge ref_clk_i);
    #1;
    check({12'h0, cs_n_o, sclk_o, busy_o}, {12'h0, spi_master_serial_port_pkg::CS_N_RST, 2'h0});
    check(rx_data_o, spi_master_serial_port_pkg::RX_RST);
    @(posedge ref_clk_i);
    rst_i <= 1'h0;
    run_frame(16'h0002, 16'h0001, 5'h02, 8'h07, 4'b1000, 8'h00, 8'h00, 8'h00, 1'h0);
    run_frame(16'ha5c3, 16'h3c5a, 5'h10, 8'h07, 4'b1101, 8'h03, 8'h02, 8'h00, 1'h1);
    run_frame(16'h00b4, 16'h0069, 5'h08, 8'h05, 4'b0010, 8'h00, 8'h01, 8'h00, 1'h0);
    run_frame(16'h0013, 16'h000c, 5'h05, 8'h09, 4'b1111, 8'h01, 8'h00, 8'h14, 1'h0);
    run_frame(16'h0001, 16'h0002, 5'h01, 8'h07, 4'b1000, 8'h00, 8'h00, 8'h00, 1'h0);
    run_frame(16'h1234, 16'hfedc, 5'h1f, 8'h07, 4'b1001, 8'h02, 8'h03, 8'h00, 1'h0);
    give_verdict();
  end

  // Six frames of at most about 280 cycles each; this limit leaves ample margin.
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    errors++;
    give_verdict();
  end
endmodule
